// [rtl/boot_page_defines.svh]
// addresses, field positions, reset values and timing counts of the boot, page and enable control
`ifndef BOOT_PAGE_DEFINES_SVH
`define BOOT_PAGE_DEFINES_SVH

`define CLK_PERIOD_NS 40
`define CONV_TIME_NS 8300
`define CONV_CYC (`CONV_TIME_NS / `CLK_PERIOD_NS)
`define BOOT_TIME_NS 1500000
`define BOOT_MAX_CYC (`BOOT_TIME_NS / `CLK_PERIOD_NS)
`define RST_BASE_NS 10000
`define RST_BASE_CYC (`RST_BASE_NS / `CLK_PERIOD_NS)

`define NUM_CH 12
`define REG_RESET 8'h00
`define RANGE_OFF 2'b11

`define NV_COPY_FIRST 8'h0F
`define NV_COPY_LAST 8'h7D

`define DF_RANGE0 7'h0F
`define DF_RANGE1 7'h10
`define DF_RANGE2 7'h11
`define DF_RST_CFG 7'h15
`define DF_FLT1_LO 7'h16
`define DF_FLT1_HI 7'h17
`define DF_FLT2_LO 7'h18
`define DF_FLT2_HI 7'h19
`define DF_THR_BASE 7'h23
`define DF_FLT_MODE 7'h47
`define DF_CRIT_LO 7'h48
`define DF_CRIT_HI 7'h49
`define DF_LOG_LO 7'h4A
`define DF_LOG_HI 7'h4B
`define DF_SW_EN 7'h4D
`define SW_EN_ADDR 8'h4D
`define SW_EN_USED_MASK 8'h0F
`define SW_EN_BIT 0
`define MARGIN_BIT 1
`define EW_SEL_BIT 2
`define WDOG_BIT 3
`define LATCH_MODE_BIT 0

`define EXT_RESULT_LAST 8'h17
`define EXT_FLAG_LO 8'h18
`define EXT_FLAG_HI 8'h19
`define EXT_GPIO_DATA 8'h1A
`define EXT_GPIO_DIR 8'h1B
`define EXT_DAC_EN_LO 8'h1C
`define EXT_DAC_EN_HI 8'h1D

`define CMD_I2C_EXT 8'h98
`define CMD_I2C_EXT_EXIT 8'h99
`define CMD_I2C_NV 8'h9A
`define CMD_I2C_NV_EXIT 8'h9B
`define CMD_JTAG_EXT 8'h09
`define CMD_JTAG_EXT_EXIT 8'h0A
`define CMD_JTAG_NV 8'h0B
`define CMD_JTAG_NV_EXIT 8'h0C

`define LOG_LAST_IDX 4'hE
`define LOG_LAST_ADDR 8'h0E
`define LOG_MARK 8'h01

`endif

// [rtl/boot_page_pkg.sv]
// types shared by the boot, page and enable control
`default_nettype none
package boot_page_pkg;
	typedef enum logic [1:0] {ST_BOOT, ST_RUN, ST_LOG} boot_state_t;
	typedef enum logic [1:0] {PG_DEFAULT, PG_EXTENDED, PG_NONVOL} page_t;
endpackage : boot_page_pkg
`default_nettype wire

// [rtl/conv_scanner.sv]
// channel scanner: steps the converter through enabled channels and reports results
`include "boot_page_defines.svh"
`default_nettype none
module conv_scanner (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic run,
	input wire logic [23:0] range_sel,
	input wire logic [9:0] adc_result,
	output logic [3:0] adc_channel,
	output logic adc_start,
	output logic done,
	output logic [3:0] done_ch,
	output logic [9:0] done_val
);
	logic busy_r;
	logic [7:0] cnt_r;
	wire chan_off_w = (range_sel[{adc_channel, 1'b0} +: 2] == `RANGE_OFF);
	wire [3:0] next_ch_w = (adc_channel == 4'(`NUM_CH - 1)) ? 4'h0 : adc_channel + 4'h1;

	always_ff @(posedge ref_clk) begin
		if (reset || !run) begin
			adc_channel <= 4'h0;
			busy_r <= 1'b0;
			cnt_r <= 8'h00;
			adc_start <= 1'b0;
			done <= 1'b0;
			done_ch <= 4'h0;
			done_val <= 10'h000;
		end else begin
			adc_start <= 1'b0;
			done <= 1'b0;
			if (!busy_r) begin
				if (chan_off_w) begin
					adc_channel <= next_ch_w;
				end else begin
					busy_r <= 1'b1;
					adc_start <= 1'b1;
					cnt_r <= 8'(`CONV_CYC - 1);
				end
			end else if (cnt_r == 8'h00) begin
				busy_r <= 1'b0;
				done <= 1'b1;
				done_ch <= adc_channel;
				done_val <= adc_result;
				adc_channel <= next_ch_w;
			end else begin
				cnt_r <= cnt_r - 8'h01;
			end
		end
	end

	AST_CONV_TIME:
	assert property (@(posedge ref_clk) disable iff (reset || !run) adc_start |-> ##207 done)
		else $error("conversion did not finish in 207 cycles");
	AST_SKIP_OFF:
	assert property (@(posedge ref_clk) disable iff (reset) adc_start |-> range_sel[{adc_channel, 1'b0} +: 2] != 2'b11)
		else $error("disabled channel was converted");
endmodule : conv_scanner
`default_nettype wire

// [rtl/boot_page_enable_control.sv]
// boot loader, page selection, enable gating, fault flags and fault logging of the supply manager
`include "boot_page_defines.svh"
`default_nettype none
module boot_page_enable_control #(
	parameter int BOOT_LIMIT_CYC = `BOOT_MAX_CYC
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic en_pin,
	input wire logic [5:0] gpio_in,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic cmd_valid,
	input wire logic cmd_jtag,
	input wire logic [7:0] cmd_code,
	input wire logic reboot_req,
	output logic serial_ready,
	output logic [7:0] nv_addr,
	input wire logic [7:0] nv_rdata,
	output logic nv_wr,
	output logic [7:0] nv_wdata,
	input wire logic [9:0] adc_result,
	output logic [3:0] adc_channel,
	output logic adc_start,
	output logic [95:0] trim_voltage_output_code,
	output logic [11:0] trim_voltage_output_oe,
	output logic [11:0] gate_out,
	output logic [11:0] gate_oe,
	output logic [5:0] gpio_out,
	output logic [5:0] gpio_oe,
	output logic reset_out_n,
	output logic [1:0] fault_out,
	output logic early_warning,
	output logic margin_en,
	output logic ew_overvoltage,
	output logic wdog_independent,
	output logic log_locked
);
	boot_page_pkg::boot_state_t st_r, st_nxt;
	boot_page_pkg::page_t page_r, page_nxt;
	logic [7:0] dflt_r [0:127];
	logic [7:0] res_r [0:23];
	logic en_s1_r, en_s2_r;
	logic [5:0] gpio_s1_r, gpio_s2_r;
	logic [11:0] fault_r, ew_r, dac_en_r;
	logic [5:0] gpio_dir_r;
	logic latch_r, rd_pend_r;
	logic [7:0] rd_addr_r;
	boot_page_pkg::page_t rd_page_r;
	logic [3:0] log_idx_r;
	logic [10:0] rst_cnt_r;
	logic [15:0] boot_cyc_r;
	logic scan_done;
	logic [3:0] scan_ch;
	logic [9:0] scan_val;
	logic [11:0] viol_w, ew_hit_w;

	// pin inputs come from outside the clock domain
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			en_s1_r <= 1'b0;
			en_s2_r <= 1'b0;
			gpio_s1_r <= 6'h00;
			gpio_s2_r <= 6'h00;
		end else begin
			en_s1_r <= en_pin;
			en_s2_r <= en_s1_r;
			gpio_s1_r <= gpio_in;
			gpio_s2_r <= gpio_s1_r;
		end
	end

	wire in_boot_w = (st_r == boot_page_pkg::ST_BOOT);
	wire in_run_w = (st_r == boot_page_pkg::ST_RUN);
	wire in_log_w = (st_r == boot_page_pkg::ST_LOG);
	// the software enable bit reads 0 in RAM before boot; boot itself keeps everything disabled
	wire sw_disable_w = dflt_r[`DF_SW_EN][`SW_EN_BIT];
	wire mon_en_w = !in_boot_w && !(in_run_w && reboot_req) && en_s2_r && !sw_disable_w;
	wire scan_run_w = mon_en_w && in_run_w;
	wire host_ok_w = in_run_w;
	wire [11:0] crit_mask_w = {dflt_r[`DF_CRIT_HI][3:0], dflt_r[`DF_CRIT_LO]};
	wire [11:0] log_mask_w = {dflt_r[`DF_LOG_HI][3:0], dflt_r[`DF_LOG_LO]};
	wire [11:0] flt1_mask_w = {dflt_r[`DF_FLT1_HI][3:0], dflt_r[`DF_FLT1_LO]};
	wire [11:0] flt2_mask_w = {dflt_r[`DF_FLT2_HI][3:0], dflt_r[`DF_FLT2_LO]};
	wire latch_mode_w = dflt_r[`DF_FLT_MODE][`LATCH_MODE_BIT];
	wire crit_now_w = |(fault_r & crit_mask_w);
	wire trip_w = crit_now_w || latch_r;
	wire [7:0] msb_w = scan_val[9:2];

	conv_scanner u_scan (
		.ref_clk(ref_clk),
		.reset(reset),
		.run(scan_run_w),
		.range_sel({dflt_r[`DF_RANGE2], dflt_r[`DF_RANGE1], dflt_r[`DF_RANGE0]}),
		.adc_result(adc_result),
		.adc_channel(adc_channel),
		.adc_start(adc_start),
		.done(scan_done),
		.done_ch(scan_ch),
		.done_val(scan_val)
	);

	genvar g;
	generate
		for (g = 0; g < `NUM_CH; g++) begin : g_ch
			// limits per channel: overvoltage, undervoltage, early warning
			assign viol_w[g] = (msb_w > dflt_r[`DF_THR_BASE + 3 * g]) || (msb_w < dflt_r[`DF_THR_BASE + 3 * g + 1]);
			assign ew_hit_w[g] = dflt_r[`DF_SW_EN][`EW_SEL_BIT] ? (msb_w > dflt_r[`DF_THR_BASE + 3 * g + 2])
				: (msb_w < dflt_r[`DF_THR_BASE + 3 * g + 2]);
			assign trim_voltage_output_code[8 * g +: 8] = dflt_r[g];
		end
	endgenerate

	// page commands, decoded for either serial port
	wire cmd_ok_w = cmd_valid && host_ok_w;
	wire go_ext_w = cmd_ok_w && (cmd_jtag ? cmd_code == `CMD_JTAG_EXT : cmd_code == `CMD_I2C_EXT);
	wire go_nv_w = cmd_ok_w && (cmd_jtag ? cmd_code == `CMD_JTAG_NV : cmd_code == `CMD_I2C_NV);
	wire exit_w = cmd_ok_w && (cmd_jtag ? (cmd_code == `CMD_JTAG_EXT_EXIT || cmd_code == `CMD_JTAG_NV_EXIT)
		: (cmd_code == `CMD_I2C_EXT_EXIT || cmd_code == `CMD_I2C_NV_EXIT));
	always_comb begin
		page_nxt = page_r;
		if (in_boot_w) begin
			page_nxt = boot_page_pkg::PG_DEFAULT;
		end else if (go_ext_w) begin
			page_nxt = boot_page_pkg::PG_EXTENDED;
		end else if (go_nv_w) begin
			page_nxt = boot_page_pkg::PG_NONVOL;
		end else if (exit_w) begin
			page_nxt = boot_page_pkg::PG_DEFAULT;
		end
	end

	// host register writes
	wire wr_ok_w = reg_wr && host_ok_w;
	wire wr_dflt_w = wr_ok_w && page_r == boot_page_pkg::PG_DEFAULT && !reg_addr[7];
	wire wr_ext_w = wr_ok_w && page_r == boot_page_pkg::PG_EXTENDED;
	wire wr_nv_w = wr_ok_w && page_r == boot_page_pkg::PG_NONVOL && !(log_locked && reg_addr <= `LOG_LAST_ADDR);
	wire boot_cp_w = in_boot_w;
	wire [7:0] dwr_addr_w = boot_cp_w ? nv_addr : reg_addr;
	wire [7:0] dwr_raw_w = boot_cp_w ? nv_rdata : reg_wdata;
	wire [7:0] dwr_data_w = (dwr_addr_w == `SW_EN_ADDR) ? (dwr_raw_w & `SW_EN_USED_MASK) : dwr_raw_w;
	wire log_hit_w = scan_done && viol_w[scan_ch] && !fault_r[scan_ch] && log_mask_w[scan_ch] && !log_locked;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			dflt_r <= '{default: `REG_RESET};
		end else if (boot_cp_w || wr_dflt_w) begin
			dflt_r[dwr_addr_w[6:0]] <= dwr_data_w;
		end
	end

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			boot_page_pkg::ST_BOOT: if (nv_addr == `NV_COPY_LAST) st_nxt = boot_page_pkg::ST_RUN;
			boot_page_pkg::ST_RUN: begin
				if (reboot_req) begin
					st_nxt = boot_page_pkg::ST_BOOT;
				end else if (log_hit_w) begin
					st_nxt = boot_page_pkg::ST_LOG;
				end
			end
			boot_page_pkg::ST_LOG: if (log_idx_r == `LOG_LAST_IDX) st_nxt = boot_page_pkg::ST_RUN;
			default: st_nxt = boot_page_pkg::ST_BOOT;
		endcase
	end

	wire [7:0] log_byte_w = (log_idx_r < 4'(`NUM_CH)) ? res_r[{log_idx_r, 1'b0}] :
		(log_idx_r == 4'hC) ? fault_r[7:0] : (log_idx_r == 4'hD) ? {4'h0, fault_r[11:8]} : `LOG_MARK;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			st_r <= boot_page_pkg::ST_BOOT;
			page_r <= boot_page_pkg::PG_DEFAULT;
			nv_addr <= `NV_COPY_FIRST;
			nv_wr <= 1'b0;
			nv_wdata <= 8'h00;
			log_idx_r <= 4'h0;
			log_locked <= 1'b0;
		end else begin
			st_r <= st_nxt;
			page_r <= page_nxt;
			nv_wr <= 1'b0;
			if (in_boot_w) begin
				nv_addr <= nv_addr + 8'h01;
			end else if (in_log_w) begin
				nv_wr <= 1'b1;
				nv_addr <= {4'h0, log_idx_r};
				nv_wdata <= log_byte_w;
				log_idx_r <= log_idx_r + 4'h1;
				if (log_idx_r == `LOG_LAST_IDX) log_locked <= 1'b1;
			end else if (in_run_w && reboot_req) begin
				nv_addr <= `NV_COPY_FIRST;
			end else if (wr_nv_w) begin
				nv_wr <= 1'b1;
				nv_addr <= reg_addr;
				nv_wdata <= reg_wdata;
			end else if (reg_rd && host_ok_w && page_r == boot_page_pkg::PG_NONVOL) begin
				nv_addr <= reg_addr;
			end
			if (!in_log_w) log_idx_r <= 4'h0;
		end
	end

	// conversion results survive a reboot; only power-on reset clears them
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			res_r <= '{default: `REG_RESET};
		end else if (scan_done) begin
			res_r[{scan_ch, 1'b0}] <= msb_w;
			res_r[{scan_ch, 1'b1}] <= {scan_val[1:0], 6'h00};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset || !mon_en_w) begin
			fault_r <= 12'h000;
			ew_r <= 12'h000;
		end else if (scan_done) begin
			fault_r[scan_ch] <= viol_w[scan_ch];
			ew_r[scan_ch] <= ew_hit_w[scan_ch];
		end
	end

	// a latched trip holds until the enable pin or bit is toggled or a reboot is requested
	always_ff @(posedge ref_clk) begin
		if (reset || !mon_en_w) begin
			latch_r <= 1'b0;
		end else if (crit_now_w && latch_mode_w) begin
			latch_r <= 1'b1;
		end
	end

	wire [7:0] rst_cfg_w = dflt_r[`DF_RST_CFG];
	wire [10:0] rst_tmo_w = 11'((rst_cfg_w[2:0] + 11'h001) * `RST_BASE_CYC);
	wire all_ok_w = mon_en_w && fault_r == 12'h000;
	always_ff @(posedge ref_clk) begin
		if (reset || in_boot_w || !all_ok_w) begin
			rst_cnt_r <= 11'h000;
			reset_out_n <= 1'b0;
		end else begin
			if (rst_cnt_r != rst_tmo_w) rst_cnt_r <= rst_cnt_r + 11'h001;
			reset_out_n <= (rst_cnt_r == rst_tmo_w);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			gate_out <= 12'h000;
			gate_oe <= 12'h000;
			gpio_out <= 6'h00;
			gpio_dir_r <= 6'h00;
			gpio_oe <= 6'h00;
			dac_en_r <= 12'h000;
			trim_voltage_output_oe <= 12'h000;
			fault_out <= 2'b00;
			early_warning <= 1'b0;
			serial_ready <= 1'b0;
		end else begin
			gate_out <= (mon_en_w && !trip_w) ? 12'hFFF : 12'h000;
			gate_oe <= in_boot_w ? 12'h000 : 12'hFFF;
			gpio_oe <= in_boot_w ? 6'h00 : gpio_dir_r;
			trim_voltage_output_oe <= in_boot_w ? 12'h000 : dac_en_r;
			fault_out <= {|(fault_r & flt2_mask_w), |(fault_r & flt1_mask_w)};
			early_warning <= |ew_r;
			serial_ready <= in_run_w && !reboot_req && !log_hit_w;
			if (wr_ext_w && reg_addr == `EXT_GPIO_DATA) gpio_out <= reg_wdata[5:0];
			if (wr_ext_w && reg_addr == `EXT_GPIO_DIR) gpio_dir_r <= reg_wdata[5:0];
			if (wr_ext_w && reg_addr == `EXT_DAC_EN_LO) dac_en_r[7:0] <= reg_wdata;
			if (wr_ext_w && reg_addr == `EXT_DAC_EN_HI) dac_en_r[11:8] <= reg_wdata[3:0];
		end
	end

	assign margin_en = dflt_r[`DF_SW_EN][`MARGIN_BIT];
	assign ew_overvoltage = dflt_r[`DF_SW_EN][`EW_SEL_BIT];
	assign wdog_independent = dflt_r[`DF_SW_EN][`WDOG_BIT];

	// reads answer two cycles after the strobe so the nonvolatile page can be fetched
	wire [7:0] ext_rd_w = (rd_addr_r <= `EXT_RESULT_LAST) ? res_r[rd_addr_r[4:0]] :
		(rd_addr_r == `EXT_FLAG_LO) ? fault_r[7:0] :
		(rd_addr_r == `EXT_FLAG_HI) ? {4'h0, fault_r[11:8]} :
		(rd_addr_r == `EXT_GPIO_DATA) ? {2'h0, gpio_s2_r} :
		(rd_addr_r == `EXT_GPIO_DIR) ? {2'h0, gpio_dir_r} :
		(rd_addr_r == `EXT_DAC_EN_LO) ? dac_en_r[7:0] :
		(rd_addr_r == `EXT_DAC_EN_HI) ? {4'h0, dac_en_r[11:8]} : 8'h00;
	wire [7:0] dflt_rd_w = rd_addr_r[7] ? 8'h00 : dflt_r[rd_addr_r[6:0]];
	wire [7:0] rd_mux_w = (rd_page_r == boot_page_pkg::PG_NONVOL) ? nv_rdata :
		(rd_page_r == boot_page_pkg::PG_EXTENDED) ? ext_rd_w : dflt_rd_w;
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rd_pend_r <= 1'b0;
			rd_addr_r <= 8'h00;
			rd_page_r <= boot_page_pkg::PG_DEFAULT;
			reg_rvalid <= 1'b0;
			reg_rdata <= 8'h00;
		end else begin
			rd_pend_r <= reg_rd && host_ok_w && !reboot_req && !log_hit_w;
			rd_addr_r <= reg_addr;
			rd_page_r <= page_r;
			reg_rvalid <= rd_pend_r;
			if (rd_pend_r) reg_rdata <= rd_mux_w;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset || !in_boot_w) begin
			boot_cyc_r <= 16'h0000;
		end else begin
			boot_cyc_r <= boot_cyc_r + 16'h0001;
		end
	end

	AST_RESULT_STORE:
	assert property (@(posedge ref_clk) disable iff (reset) scan_done |=> res_r[{$past(scan_ch), 1'b0}] == $past(scan_val[9:2]))
		else $error("conversion result not stored");
	AST_FAULT_OUT:
	assert property (@(posedge ref_clk) disable iff (reset) fault_out[0] |-> |($past(fault_r) & $past(flt1_mask_w)))
		else $error("fault output without a masked fault");
	AST_LOG_LOCK:
	assert property (@(posedge ref_clk) disable iff (reset) (in_log_w && log_idx_r == 4'hE) |=> log_locked && nv_wr)
		else $error("log not locked after last write");
	AST_POR_CLEAR:
	assert property (@(posedge ref_clk) reset |=> res_r[0] == 8'h00 && dflt_r[0] == 8'h00 && nv_addr == 8'h0F)
		else $error("registers not cleared at reset");
	AST_BOOT_NO_SCAN:
	assert property (@(posedge ref_clk) disable iff (reset) in_boot_w |-> !adc_start && fault_r == 12'h000)
		else $error("monitoring active during boot");
	AST_BOOT_TIME:
	assert property (@(posedge ref_clk) disable iff (reset) int'(boot_cyc_r) < BOOT_LIMIT_CYC)
		else $error("boot took too long");
	AST_BOOT_HIZ:
	assert property (@(posedge ref_clk) disable iff (reset) in_boot_w |=> gate_oe == 12'h000 && gpio_oe == 6'h00
		&& trim_voltage_output_oe == 12'h000 && !reset_out_n)
		else $error("outputs driven during boot");
	AST_PAGE_EXT:
	assert property (@(posedge ref_clk) disable iff (reset) go_ext_w |=> page_r == boot_page_pkg::PG_EXTENDED)
		else $error("extended page not selected");
	AST_PAGE_NV:
	assert property (@(posedge ref_clk) disable iff (reset) go_nv_w && !go_ext_w |=> page_r == boot_page_pkg::PG_NONVOL)
		else $error("nonvolatile page not selected");
	AST_DISABLE:
	assert property (@(posedge ref_clk) disable iff (reset) !mon_en_w |=> gate_out == 12'h000 && !adc_start)
		else $error("supplies or monitoring left on while disabled");
	AST_TRIP_OFF:
	assert property (@(posedge ref_clk) disable iff (reset) crit_now_w |=> gate_out == 12'h000)
		else $error("gates not switched off on fault");
endmodule : boot_page_enable_control
`default_nettype wire

// [bench/nv_adc_model.sv]
// nonvolatile memory image and converter levels facing the block
`default_nettype none
module nv_adc_model (
	input wire logic ref_clk,
	input wire logic [7:0] nv_addr,
	output logic [7:0] nv_rdata,
	input wire logic nv_wr,
	input wire logic [7:0] nv_wdata,
	input wire logic [3:0] adc_channel,
	output logic [9:0] adc_result
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:255];
	logic [9:0] level [0:15];
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'h00;
		end
		for (int i = 0; i < 16; i++) begin
			level[i] = 10'h000;
		end
		mem[8'h4D] = 8'h01;
		mem[8'h20] = 8'hA5;
		mem[8'h7D] = 8'h3C;
		mem[8'h0E] = 8'h77;
	end
	assign nv_rdata = mem[nv_addr];
	assign adc_result = level[adc_channel];
	always @(posedge ref_clk) begin
		if (nv_wr) begin
			mem[nv_addr] <= nv_wdata;
		end
	end
endmodule : nv_adc_model
`default_nettype wire

// [bench/tb_top.sv]
// bench: boot, paging, enable and fault logging scenarios
`include "boot_page_defines.svh"
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk, reset, en_pin, reg_wr, reg_rd, reg_rvalid, cmd_valid, cmd_jtag, reboot_req, serial_ready;
	logic nv_wr, adc_start, reset_out_n, early_warning, margin_en, ew_overvoltage, wdog_independent, log_locked;
	logic [5:0] gpio_in, gpio_out, gpio_oe;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, cmd_code, nv_addr, nv_rdata, nv_wdata, d;
	logic [9:0] adc_result;
	logic [3:0] adc_channel;
	logic [95:0] trim_voltage_output_code;
	logic [11:0] trim_voltage_output_oe, gate_out, gate_oe;
	logic [1:0] fault_out;
	logic [7:0] codes [8] = '{`CMD_I2C_EXT, `CMD_I2C_EXT_EXIT, `CMD_I2C_NV, `CMD_I2C_NV_EXIT,
		`CMD_JTAG_EXT, `CMD_JTAG_EXT_EXIT, `CMD_JTAG_NV, `CMD_JTAG_NV_EXIT};
	int err_total = 0;
	int total_checks = 0;
	int cycles = 0;
	boot_page_enable_control u_boot_page_enable_control (.ref_clk(ref_clk), .reset(reset), .en_pin(en_pin),
		.gpio_in(gpio_in), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .cmd_valid(cmd_valid), .cmd_jtag(cmd_jtag),
		.cmd_code(cmd_code), .reboot_req(reboot_req), .serial_ready(serial_ready), .nv_addr(nv_addr),
		.nv_rdata(nv_rdata), .nv_wr(nv_wr), .nv_wdata(nv_wdata), .adc_result(adc_result),
		.adc_channel(adc_channel), .adc_start(adc_start), .trim_voltage_output_code(trim_voltage_output_code),
		.trim_voltage_output_oe(trim_voltage_output_oe), .gate_out(gate_out), .gate_oe(gate_oe),
		.gpio_out(gpio_out), .gpio_oe(gpio_oe), .reset_out_n(reset_out_n), .fault_out(fault_out),
		.early_warning(early_warning), .margin_en(margin_en), .ew_overvoltage(ew_overvoltage),
		.wdog_independent(wdog_independent), .log_locked(log_locked));
	nv_adc_model u_nv_adc_model (.ref_clk(ref_clk), .nv_addr(nv_addr), .nv_rdata(nv_rdata), .nv_wr(nv_wr),
		.nv_wdata(nv_wdata), .adc_channel(adc_channel), .adc_result(adc_result));
	initial ref_clk = 1'b0;
	always #20 ref_clk = ~ref_clk;
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : tally_and_finish
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick
	task automatic wait_ready();
		int k;
		k = 0;
		while (serial_ready !== 1'b1 && k < 2000) begin
			tick(1);
			k++;
		end
		chk(k < 2000, 12'h001, "ready");
	endtask : wait_ready
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		tick(1);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = v;
		tick(1);
		reg_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		int k;
		tick(1);
		reg_rd = 1'b1;
		reg_addr = a;
		tick(1);
		reg_rd = 1'b0;
		v = 8'hXX;
		k = 0;
		while (reg_rvalid !== 1'b1 && k < 4) begin
			tick(1);
			k++;
		end
		if (reg_rvalid === 1'b1) v = reg_rdata;
	endtask : rd
	// one serial port per command, never both at once
	task automatic cmd(input logic j, input logic [7:0] c);
		tick(1);
		cmd_valid = 1'b1;
		cmd_jtag = j;
		cmd_code = c;
		tick(1);
		cmd_valid = 1'b0;
	endtask : cmd
	initial begin
		{reg_wr, reg_rd, cmd_valid, cmd_jtag, reboot_req} = 5'b00000;
		{reg_addr, reg_wdata, cmd_code} = 24'h000000;
		reset = 1'b1;
		en_pin = 1'b1;
		gpio_in = 6'h2D;
		tick(10);
		reset = 1'b0;
		tick(1);
		chk({gate_oe | trim_voltage_output_oe}, 12'h000, "boot oe");
		chk(gpio_oe, 12'h000, "boot gpio oe");
		chk({reset_out_n, serial_ready}, 12'h000, "boot rst");
		wait_ready();
		rd(`SW_EN_ADDR, d); chk(d, 12'h001, "sw en");
		rd(8'h20, d); chk(d, 12'h0A5, "copy");
		rd(8'h7D, d); chk(d, 12'h03C, "copy end");
		rd(8'h0E, d); chk(d, 12'h000, "not copied");
		rd(8'h00, d); chk(d | trim_voltage_output_code[11:0], 12'h000, "trim");
		wr(`SW_EN_ADDR, 8'h0F);
		chk({margin_en, ew_overvoltage, wdog_independent}, 12'h007, "cfg");
		wr(`SW_EN_ADDR, 8'hF3);
		rd(`SW_EN_ADDR, d); chk(d, 12'h003, "unused");
		chk({margin_en, ew_overvoltage, wdog_independent}, 12'h004, "cfg2");
		$display("test boot and config done");
		for (int j = 0; j < 2; j++) begin
			cmd(j, codes[4*j]);
			rd(8'h1A, d); chk(d, 12'h02D, "ext");
			cmd(j, codes[4*j+1]);
			rd(8'h20, d); chk(d, 12'h0A5, "dflt");
			cmd(j, codes[4*j+2]);
			rd(8'h0E, d); chk(d, 12'h077, "nv");
			cmd(j, codes[4*j+3]);
			rd(8'h20, d); chk(d, 12'h0A5, "dflt2");
		end
		$display("test pages done");
		u_nv_adc_model.level[0] = 10'h101;
		wr(8'h0F, 8'hFC);
		wr(8'h10, 8'hFF);
		wr(8'h11, 8'hFF);
		wr(8'h23, 8'h80);
		wr(8'h24, 8'h10);
		wr(8'h25, 8'h50);
		wr(8'h47, 8'h01);
		wr(8'h16, 8'h01);
		wr(8'h48, 8'h01);
		wr(8'h4A, 8'h01);
		wr(`SW_EN_ADDR, 8'h00);
		tick(700);
		chk(gate_out, 12'hFFF, "run");
		chk(reset_out_n, 12'h001, "rst out");
		en_pin = 1'b0;
		tick(10);
		chk(gate_out, 12'h000, "disable");
		en_pin = 1'b1;
		tick(700);
		cmd(0, `CMD_I2C_EXT);
		rd(8'h00, d); chk(d, 12'h040, "msb");
		rd(8'h01, d); chk(d, 12'h040, "lsb");
		rd(8'h18, d); chk(d, 12'h000, "no flag");
		chk(early_warning, 12'h001, "ew");
		wr(8'h1A, 8'h15);
		wr(8'h1B, 8'h3F);
		wr(8'h1C, 8'hA5);
		wr(8'h1D, 8'h0F);
		tick(1);
		chk(gpio_out, 12'h015, "gpio out");
		chk(gpio_oe, 12'h03F, "gpio oe");
		chk(trim_voltage_output_oe, 12'hFA5, "trim oe");
		chk(gate_oe, 12'hFFF, "gate oe");
		u_nv_adc_model.level[0] = 10'h3FC;
		tick(600);
		rd(8'h18, d); chk(d, 12'h001, "flag");
		chk(gate_out, 12'h000, "gates off");
		chk(fault_out, 12'h001, "fault out");
		chk({early_warning, reset_out_n}, 12'h000, "fault rst");
		chk(log_locked, 12'h001, "locked");
		chk(u_nv_adc_model.mem[8'h00], 12'h0FF, "log0");
		chk(u_nv_adc_model.mem[8'h0C], 12'h001, "log12");
		chk(u_nv_adc_model.mem[8'h0E], 12'h001, "log14");
		u_nv_adc_model.level[0] = 10'h101;
		tick(600);
		chk(gate_out, 12'h000, "latched");
		en_pin = 1'b0;
		tick(10);
		en_pin = 1'b1;
		tick(10);
		chk(gate_out, 12'hFFF, "restart");
		$display("test monitor and log done");
		tick(1);
		reboot_req = 1'b1;
		tick(1);
		reboot_req = 1'b0;
		tick(2);
		wait_ready();
		cmd(0, `CMD_I2C_EXT);
		rd(8'h00, d); chk(d, 12'h040, "kept");
		$display("test reboot done");
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
